/* src/sos_pkg.sv */
// package: types, register map and timing constants of the safety output block
package sos_pkg;
  localparam int NIN = 22;
  localparam int NSO = 3;
  localparam int NST = 10;
  localparam int NVS = 32;
  localparam int NSRC = NST + NVS;
  localparam int LAMP0 = 8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_MS = 100;
  localparam int HOLD_MS = 500;
  localparam int DLY_MAX_MS = 300000;
  localparam logic [11:0] HOLD_TICKS = 12'(HOLD_MS / TICK_MS);
  localparam logic [11:0] DLY_MAX_STEPS = 12'(DLY_MAX_MS / TICK_MS);
  // word indexes of the registers; byte address is four times the index
  localparam logic [7:0] A_MAP = 8'h00;
  localparam logic [7:0] A_OCFG = 8'h03;
  localparam logic [7:0] A_MUTE = 8'h06;
  localparam logic [7:0] A_BYP = 8'h07;
  localparam logic [7:0] A_GRP = 8'h08;
  localparam logic [7:0] A_CTRL = 8'h09;
  localparam logic [7:0] A_STAT = 8'h0A;
  localparam logic [7:0] A_VSO = 8'h0B;
  localparam logic [7:0] A_SCFG = 8'h40;
  // control word bit positions
  localparam int CTRL_LAMP = 0;
  localparam int CTRL_SYSRST = 1;
  localparam int CTRL_CLR = 2;
  // all registers reset to zero except the system reset request
  localparam logic SYSRST_RST = 1'b1;
  typedef enum logic [3:0] {
    SRC_RUN, SRC_ON, SRC_LON, SRC_LOCK, SRC_IOF, SRC_SYSRST,
    SRC_ORST, SRC_MUTED, SRC_FIRST, SRC_BYP, SRC_INFLT, SRC_CANCEL
  } sos_src_t;
  // output config: [13] manual reset, [12] off-delay, [11:0] steps of 100 ms
  typedef struct packed {
    logic manual;
    logic offd;
    logic [11:0] steps;
  } sos_ocfg_t;
  // status config: [9] active low, [8:5] source, [4:0] input or output index
  typedef struct packed {
    logic pol;
    sos_src_t src;
    logic [4:0] idx;
  } sos_scfg_t;
  typedef enum logic [2:0] {CH_OFF, CH_ONDLY, CH_ON, CH_OFFDLY, CH_HOLD} sos_ch_state_t;
  typedef struct packed {
    logic on;
    logic lon;
    logic rst_need;
    logic cancel;
    logic hold;
  } sos_ch_t;
  typedef struct packed {
    logic [NIN-1:0] run;
    logic [NIN-1:0] fault;
    logic sc_ok;
    logic rst_btn;
    logic mute;
    logic byp;
    logic [NSO-1:0] fb;
    logic [1:0] open;
    logic [1:0] short_c;
  } sos_pins_t;
  // status word, bit 0 is on[0]
  typedef struct packed {
    logic [NST-1:0] st;
    logic short_seen;
    logic open_seen;
    logic blk;
    logic mcyc;
    logic sys_rst;
    logic lockout;
    logic iof;
    logic [NSO-1:0] rst_need;
    logic [NSO-1:0] on;
  } sos_stat_t;
endpackage

/* src/sos_out_chan.sv */
// one safety output channel: delays, stop category, reset handling
module sos_out_chan import sos_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic go,
  input wire logic hold_off,
  input wire logic rst_pulse,
  input wire sos_ocfg_t cfg,
  output sos_ch_t st
);
  typedef struct packed {
    sos_ch_state_t state;
    logic [11:0] cnt;
  } sos_chr_t;
  sos_chr_t r;
  sos_chr_t next_r;
  logic [11:0] lim;

  // channel sequencing, delay counted in 100 ms ticks
  always_comb begin
    lim = (cfg.steps > DLY_MAX_STEPS) ? DLY_MAX_STEPS : cfg.steps;
    next_r = r;
    if (tick) begin
      next_r.cnt = r.cnt + 12'h001;
    end
    case (r.state)
      CH_OFF: begin
        next_r.cnt = 12'h000;
        // manual reset waits for a button edge, auto goes at once
        if (go && !hold_off && (!cfg.manual || rst_pulse)) begin
          next_r.state = (!cfg.offd && lim != 12'h000) ? CH_ONDLY : CH_ON;
        end
      end
      CH_ONDLY: begin
        if (!go) begin
          next_r.state = CH_OFF;
        // one tick past the limit, so a tick right at entry cannot shorten the delay
        end else if (r.cnt > lim) begin
          next_r.state = CH_ON;
        end
      end
      CH_ON: begin
        next_r.cnt = 12'h000;
        if (!go) begin
          next_r.state = (cfg.offd && lim != 12'h000) ? CH_OFFDLY : CH_OFF;
        end
      end
      CH_OFFDLY: begin
        // a reclosed input does not cancel the running delay
        if (r.cnt > lim) begin
          next_r.state = CH_HOLD;
          next_r.cnt = 12'h000;
        end
      end
      CH_HOLD: begin
        if (r.cnt >= HOLD_TICKS) begin
          next_r.state = CH_OFF;
        end
      end
      default: next_r.state = CH_OFF;
    endcase
  end

  // channel flags seen by the status logic
  always_comb begin
    st.on = (r.state == CH_ON) || (r.state == CH_OFFDLY);
    st.lon = st.on || (r.state == CH_ONDLY);
    st.rst_need = (r.state == CH_OFF) && cfg.manual && go && !hold_off;
    st.cancel = (r.state == CH_OFFDLY);
    st.hold = (r.state == CH_OFFDLY) || (r.state == CH_HOLD);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

/* src/sos_safety_out.sv */
// safety output and status output logic with wishbone register slave
module sos_safety_out import sos_pkg::*; #(
  parameter int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NIN-1:0] in_run,
  input wire logic [NIN-1:0] in_fault,
  input wire logic self_check_ok,
  input wire logic reset_btn,
  input wire logic mute_sens,
  input wire logic bypass_sw,
  input wire logic [NSO-1:0] out_feedback,
  input wire logic [1:0] lamp_open,
  input wire logic [1:0] lamp_short,
  output logic [1:0] safety_output_first,
  output logic [1:0] safety_output_second,
  output logic [1:0] safety_output_third,
  output logic [7:0] ordinary_status_outputs,
  output logic lamp_capable_status_out_a,
  output logic lamp_capable_status_out_b,
  output logic [NVS-1:0] virtual_status
);
  typedef struct packed {
    sos_pins_t p1;
    sos_pins_t p2;
    logic [23:0] pre;
    logic tick;
    logic btn_d;
    logic [NSO-1:0][NIN-1:0] map;
    sos_ocfg_t [NSO-1:0] ocfg;
    logic [NIN-1:0] mute_map;
    logic [NIN-1:0] byp_map;
    logic [NIN-1:0] grp;
    logic [NIN-1:0] first;
    logic [NIN-1:0] run_d;
    sos_scfg_t [NSRC-1:0] scfg;
    logic lamp_mode;
    logic sys_rst;
    logic out_fault;
    logic open_seen;
    logic short_seen;
    logic blk;
    logic mcyc;
    logic [NSO-1:0] so_a;
    logic [NSO-1:0] so_b;
    logic [NSO-1:0] od1;
    logic [NSO-1:0] od2;
    logic [NST-1:0] st;
    logic [NVS-1:0] vso;
    logic ack;
    logic [31:0] dat;
    logic [31:0] hold_len;
  } sos_state_t;

  sos_state_t r;
  sos_state_t next_r;
  sos_pins_t pins;
  sos_ch_t [NSO-1:0] ch;
  sos_stat_t stat;
  logic [NSO-1:0] go;
  logic [NSO-1:0] hold_off;
  logic [NSO-1:0] map_nz;
  logic [NSO-1:0] on_v;
  logic [NSO-1:0] lon_v;
  logic [NSO-1:0] rstn_v;
  logic [NSO-1:0] canc_v;
  logic [NIN-1:0] muted;
  logic [NIN-1:0] bypd;
  logic [NIN-1:0] eff_run;
  logic [11:0][NIN-1:0] tbl;
  logic lockout;
  logic iof;
  logic rst_pulse;
  logic req;
  logic [7:0] widx;
  logic [31:0] rd;
  logic [31:0] wd;
  logic open_ev;
  logic short_ev;

  // byte-lane merge of a wishbone write into the old value
  function automatic logic [31:0] wm(input logic [31:0] o, input logic [31:0] d,
                                     input logic [3:0] s);
    logic [31:0] v;
    v = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        v[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return v;
  endfunction

  // status source pick, shared by physical and virtual outputs
  function automatic logic sel_src(input sos_scfg_t c, input logic [11:0][NIN-1:0] t);
    logic v;
    v = 1'b0;
    if (c.src <= SRC_CANCEL && c.idx < 5'(NIN)) begin
      v = t[c.src][c.idx];
    end
    return v ^ c.pol;
  endfunction

  assign pins = {in_run, in_fault, self_check_ok, reset_btn, mute_sens, bypass_sw,
                 out_feedback, lamp_open, lamp_short};

  // input conditioning and output permission
  always_comb begin
    muted = r.mute_map & {NIN{r.mcyc}};
    bypd = r.byp_map & {NIN{r.p2.byp}};
    eff_run = r.p2.run | muted | bypd;
    lockout = r.out_fault;
    // lamp faults count as status output failures
    iof = lockout | r.open_seen | r.short_seen | (|r.p2.fault);
    rst_pulse = r.p2.rst_btn & ~r.btn_d;
    for (int k = 0; k < NSO; k++) begin
      map_nz[k] = (r.map[k] != '0);
      // an empty map never switches on
      go[k] = map_nz[k] && ((eff_run & r.map[k]) == r.map[k])
              && r.p2.sc_ok && !lockout && !r.sys_rst;
      hold_off[k] = 1'b0;
      for (int j = 0; j < NSO; j++) begin
        if (j != k && (r.map[j] & r.map[k]) != '0 && ch[j].hold) begin
          hold_off[k] = 1'b1;
        end
      end
      on_v[k] = ch[k].on;
      lon_v[k] = ch[k].lon;
      rstn_v[k] = ch[k].rst_need;
      canc_v[k] = ch[k].cancel;
    end
  end

  // per-source vectors, indexed by input or output number
  always_comb begin
    tbl = '0;
    tbl[SRC_RUN] = eff_run;
    tbl[SRC_ON] = NIN'(on_v & map_nz);
    tbl[SRC_LON] = NIN'(lon_v & map_nz);
    tbl[SRC_LOCK] = {NIN{lockout}};
    tbl[SRC_IOF] = {NIN{iof}};
    tbl[SRC_SYSRST] = {NIN{r.sys_rst}};
    tbl[SRC_ORST] = NIN'(rstn_v & map_nz);
    tbl[SRC_MUTED] = muted;
    tbl[SRC_FIRST] = r.first;
    tbl[SRC_BYP] = bypd;
    tbl[SRC_INFLT] = r.p2.fault;
    tbl[SRC_CANCEL] = NIN'(canc_v & map_nz);
  end

  // status word and register read mux
  always_comb begin
    stat.st = r.st;
    stat.short_seen = r.short_seen;
    stat.open_seen = r.open_seen;
    stat.blk = r.blk;
    stat.mcyc = r.mcyc;
    stat.sys_rst = r.sys_rst;
    stat.lockout = lockout;
    stat.iof = iof;
    stat.rst_need = rstn_v;
    stat.on = on_v;
    widx = wb_adr_i[9:2];
    req = wb_cyc_i && wb_stb_i && !r.ack;
    rd = 32'h00000000;
    case (widx)
      A_MUTE: rd = 32'(r.mute_map);
      A_BYP: rd = 32'(r.byp_map);
      A_GRP: rd = 32'(r.grp);
      A_CTRL: rd = 32'(r.lamp_mode);
      A_STAT: rd = 32'(stat);
      A_VSO: rd = r.vso;
      default: rd = 32'h00000000;
    endcase
    for (int k = 0; k < NSO; k++) begin
      if (widx == A_MAP + 8'(k)) begin
        rd = 32'(r.map[k]);
      end
      if (widx == A_OCFG + 8'(k)) begin
        rd = 32'(r.ocfg[k]);
      end
    end
    for (int i = 0; i < NSRC; i++) begin
      if (widx == A_SCFG + 8'(i)) begin
        rd = 32'(r.scfg[i]);
      end
    end
    // unmapped words read zero, so writes to them change nothing
    wd = wm(rd, wb_dat_i, wb_sel_i);
  end

  // next state of the whole block
  always_comb begin
    next_r = r;
    // two-flop synchronisers on every pin
    next_r.p1 = pins;
    next_r.p2 = r.p1;
    next_r.btn_d = r.p2.rst_btn;
    // 100 ms prescaler
    next_r.tick = 1'b0;
    next_r.pre = r.pre + 24'h000001;
    if (r.pre >= 24'(TICK_CYCLES - 1)) begin
      next_r.pre = 24'h000000;
      next_r.tick = 1'b1;
    end
    // wishbone classic: ack one cycle after the request, then drop
    next_r.ack = req;
    if (req) begin
      next_r.dat = rd;
    end
    if (req && wb_we_i) begin
      case (widx)
        A_MUTE: next_r.mute_map = wd[NIN-1:0];
        A_BYP: next_r.byp_map = wd[NIN-1:0];
        A_GRP: next_r.grp = wd[NIN-1:0];
        A_CTRL: next_r.lamp_mode = wd[CTRL_LAMP];
        default: next_r.lamp_mode = r.lamp_mode;
      endcase
      for (int k = 0; k < NSO; k++) begin
        if (widx == A_MAP + 8'(k)) begin
          next_r.map[k] = wd[NIN-1:0];
        end
        if (widx == A_OCFG + 8'(k)) begin
          next_r.ocfg[k] = wd[$bits(sos_ocfg_t)-1:0];
        end
      end
      for (int i = 0; i < NSRC; i++) begin
        if (widx == A_SCFG + 8'(i)) begin
          next_r.scfg[i] = wd[$bits(sos_scfg_t)-1:0];
        end
      end
      if (widx == A_CTRL && wd[CTRL_SYSRST]) begin
        next_r.sys_rst = 1'b0;
      end
      if (widx == A_CTRL && wd[CTRL_CLR]) begin
        next_r.out_fault = 1'b0;
        next_r.open_seen = 1'b0;
        next_r.short_seen = 1'b0;
        next_r.blk = 1'b0;
      end
    end
    // output feedback compared against the drive two cycles back
    next_r.od1 = r.so_a;
    next_r.od2 = r.od1;
    if (r.od1 == r.od2 && r.p2.fb != r.od2) begin
      next_r.out_fault = 1'b1;
    end
    // a lockout needs a fresh system reset; set wins over clear
    if (lockout) begin
      next_r.sys_rst = 1'b1;
    end
    // first input of the group to drop out
    next_r.run_d = eff_run;
    if ((eff_run & r.grp) == r.grp) begin
      next_r.first = '0;
    end else if (r.first == '0) begin
      next_r.first = r.run_d & ~eff_run & r.grp;
    end
    // lamp checks: short while lit, open while dark
    open_ev = r.lamp_mode && (r.p2.open & {2{!r.mcyc}}) != 2'b00;
    short_ev = r.lamp_mode && (r.p2.short_c & {2{r.mcyc}}) != 2'b00;
    if (open_ev) begin
      next_r.open_seen = 1'b1;
    end
    if (short_ev) begin
      next_r.short_seen = 1'b1;
    end
    // a known open refuses the start; any fault blocks the next cycle
    if (r.p2.mute && !r.mcyc && !r.blk && !r.open_seen) begin
      next_r.mcyc = 1'b1;
    end
    if (!r.p2.mute && r.mcyc) begin
      next_r.mcyc = 1'b0;
      if (r.open_seen || r.short_seen || open_ev || short_ev) begin
        next_r.blk = 1'b1;
      end
    end
    // registered drive of both redundant halves
    next_r.so_a = on_v;
    next_r.so_b = on_v;
    for (int i = 0; i < NST; i++) begin
      next_r.st[i] = sel_src(r.scfg[i], tbl);
    end
    // lamp mode overrides the two lamp-capable outputs only
    if (r.lamp_mode) begin
      next_r.st[LAMP0] = r.mcyc;
      next_r.st[LAMP0 + 1] = r.mcyc;
    end
    for (int i = 0; i < NVS; i++) begin
      next_r.vso[i] = sel_src(r.scfg[NST + i], tbl);
    end
    next_r.hold_len = (ch[0].hold && !ch[0].cancel) ? r.hold_len + 32'h00000001 : 32'h0;
  end

  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= '0;
      r.sys_rst <= SYSRST_RST;
    end else begin
      r <= next_r;
    end
  end

  // one sequencer per safety output
  generate
    for (genvar k = 0; k < NSO; k++) begin : g_ch
      sos_out_chan u_ch (
        .clk(clk),
        .resetn(resetn),
        .tick(r.tick),
        .go(go[k]),
        .hold_off(hold_off[k]),
        .rst_pulse(rst_pulse),
        .cfg(r.ocfg[k]),
        .st(ch[k])
      );
    end
  endgenerate

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign safety_output_first = {r.so_b[0], r.so_a[0]};
  assign safety_output_second = {r.so_b[1], r.so_a[1]};
  assign safety_output_third = {r.so_b[2], r.so_a[2]};
  assign ordinary_status_outputs = r.st[7:0];
  assign lamp_capable_status_out_a = r.st[LAMP0];
  assign lamp_capable_status_out_b = r.st[LAMP0 + 1];
  assign virtual_status = r.vso;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_redund;
    r.so_a == r.so_b;
  endproperty
  a_redund: assert property (p_redund) else $error("redundant halves differ");

  property p_go;
    $rose(r.so_a[0]) |-> $past(go[0], 2);
  endproperty
  a_go: assert property (p_go) else $error("output on without permission");

  property p_cat0;
    ch[0].on && !ch[0].cancel && !go[0] && !r.ocfg[0].offd |=> !ch[0].on;
  endproperty
  a_cat0: assert property (p_cat0) else $error("category 0 stop not immediate");

  property p_manual;
    $rose(ch[0].lon) && $past(r.ocfg[0].manual) |-> $past(rst_pulse);
  endproperty
  a_manual: assert property (p_manual) else $error("manual output on without reset");

  property p_hold;
    (ch[0].hold && !ch[0].cancel) ##1 !(ch[0].hold && !ch[0].cancel)
      |-> $past(r.hold_len) >= 32'(int'(HOLD_TICKS - 12'h001) * TICK_CYCLES);
  endproperty
  a_hold: assert property (p_hold) else $error("off interval too short");

  property p_tick;
    r.tick |=> !r.tick;
  endproperty
  a_tick: assert property (p_tick) else $error("tick wider than one cycle");

  property p_iof;
    (|r.p2.fault) && r.scfg[0].src == SRC_IOF && !r.scfg[0].pol |=> r.st[0];
  endproperty
  a_iof: assert property (p_iof) else $error("input fault not reported");

  property p_nomap;
    r.scfg[1].src == SRC_ON && r.scfg[1].idx == 5'h00 && r.map[0] == '0
      |=> r.st[1] == $past(r.scfg[1].pol);
  endproperty
  a_nomap: assert property (p_nomap) else $error("unmapped output shown on");

  property p_open;
    r.open_seen && !r.mcyc |=> !r.mcyc;
  endproperty
  a_open: assert property (p_open) else $error("mute started after open lamp");

  property p_short;
    $fell(r.mcyc) && $past(r.short_seen) |-> r.blk;
  endproperty
  a_short: assert property (p_short) else $error("short did not block next mute");

  property p_ack;
    r.ack |=> !r.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held two cycles");

  property p_cov_on;
    $rose(r.so_a[0]);
  endproperty
  c_cov_on: cover property (p_cov_on);

  property p_cov_hold;
    $fell(ch[0].hold);
  endproperty
  c_cov_hold: cover property (p_cov_hold);

  property p_cov_mute;
    $fell(r.mcyc) && r.blk;
  endproperty
  c_cov_mute: cover property (p_cov_mute);
endmodule

/* bench/sos_load_model.sv */
// load model: contactor readback and lamp loads behind the outputs, healthy unless lamp_broken
module sos_load_model import sos_pkg::*; (
  input wire logic [1:0] drv_first,
  input wire logic [1:0] drv_second,
  input wire logic [1:0] drv_third,
  input wire logic lamp_broken,
  output logic [NSO-1:0] feedback,
  output logic [1:0] lamp_open,
  output logic [1:0] lamp_short
);
  timeunit 1ns;
  timeprecision 1ps;
  // contacts read back at once; the design allows only its two-flop input sync as latency
  assign feedback = {&drv_third, &drv_second, &drv_first};
  // a broken filament senses open on both lamp outputs; shorts never occur
  assign lamp_open = {lamp_broken, lamp_broken};
  assign lamp_short = 2'h0;
endmodule

/* bench/test_safety_output_status_logic.sv */
// self-checking bench for the safety output and status logic
module test_safety_output_status_logic import sos_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 10;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack;
  logic [NIN-1:0] run = '0;
  logic btn = 1'b0;
  logic mute = 1'b0;
  logic broken = 1'b0;
  logic sck = 1'b1;
  logic [NIN-1:0] flt = '0;
  logic [NSO-1:0] fb;
  logic [1:0] lo, ls, so1, so2, so3;
  logic [7:0] ost;
  logic la, lb;
  logic [NVS-1:0] vs;
  int fail_count = 0, check_count = 0, cycles = 0;

  sos_safety_out #(.TICK_CYCLES(TC)) u_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .in_run(run), .in_fault(flt), .self_check_ok(sck),
    .reset_btn(btn), .mute_sens(mute), .bypass_sw(1'b0), .out_feedback(fb),
    .lamp_open(lo), .lamp_short(ls), .safety_output_first(so1), .safety_output_second(so2),
    .safety_output_third(so3), .ordinary_status_outputs(ost),
    .lamp_capable_status_out_a(la), .lamp_capable_status_out_b(lb), .virtual_status(vs));
  sos_load_model u_load (.drv_first(so1), .drv_second(so2), .drv_third(so3),
    .lamp_broken(broken), .feedback(fb), .lamp_open(lo), .lamp_short(ls));

  initial begin
    forever #4 clk = ~clk;
  end
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // classic cycle: hold everything until ack is seen high at a rising edge
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    @(posedge clk);
    // ack and read data are taken at the same rising edge, then the request drops
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    chk("so1", so1, 2'h0);
    rd(10'h028, q);
    chk("status", q, 32'h0000_0100);
    rd(10'h3FC, q);
    chk("unmapped", q, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_and_logic();
    wr(10'h000, 32'h1);
    wr(10'h004, 32'h2);
    wr(10'h008, 32'h4);
    run <= 22'h000001;
    idle(10);
    chk("so1 before system reset", so1, 2'h0);
    wr(10'h024, 32'h2);
    idle(8);
    chk("so1 on", so1, 2'h3);
    chk("so2 input stopped", so2, 2'h0);
    run <= 22'h000000;
    idle(6);
    chk("so1 stop cat 0", so1, 2'h0);
    $display("test and logic done");
  endtask
  task automatic t_on_delay();
    wr(10'h010, 32'h0000_0002);
    run <= 22'h000002;
    idle(8);
    chk("so2 during on delay", so2, 2'h0);
    idle(36);
    chk("so2 after on delay", so2, 2'h3);
    run <= 22'h000000;
    idle(6);
    chk("so2 off", so2, 2'h0);
    $display("test on delay done");
  endtask
  task automatic t_off_delay();
    int n;
    wr(10'h014, 32'h0000_1002);
    run <= 22'h000004;
    idle(8);
    chk("so3 on", so3, 2'h3);
    run <= 22'h000000;
    idle(8);
    chk("so3 in off delay", so3, 2'h3);
    n = 0;
    while (so3 !== 2'h0 && n < 40) begin
      idle(1);
      n++;
    end
    chk("so3 off after delay", so3, 2'h0);
    run <= 22'h000004;
    idle(30);
    chk("so3 held off", so3, 2'h0);
    idle(40);
    chk("so3 auto return", so3, 2'h3);
    $display("test off delay done");
  endtask
  task automatic t_manual();
    logic [31:0] q;
    wr(10'h00C, 32'h0000_2000);
    run <= 22'h000005;
    idle(10);
    chk("so1 waits for reset", so1, 2'h0);
    rd(10'h028, q);
    chk("reset needed", q[3], 1'b1);
    chk("auto so3 no reset need", q[5], 1'b0);
    @(posedge clk);
    btn <= 1'b1;
    idle(4);
    @(posedge clk);
    btn <= 1'b0;
    idle(8);
    chk("so1 after manual reset", so1, 2'h3);
    $display("test manual reset done");
  endtask
  task automatic t_status();
    logic [11:0] exp;
    exp = 12'h007;
    for (int s = 0; s < 12; s++) begin
      wr(10'h104, 32'(s) << 5);
      idle(4);
      chk("status source", ost[1], exp[s]);
    end
    wr(10'h100, 32'h0000_0020);
    idle(4);
    chk("status active high", ost[0], 1'b1);
    wr(10'h100, 32'h0000_0220);
    idle(4);
    chk("status active low", ost[0], 1'b0);
    wr(10'h120, 32'h0000_0002);
    idle(4);
    chk("lamp a ordinary", la, 1'b1);
    wr(10'h128, 32'h0000_02A0);
    idle(4);
    chk("virtual 0", vs[0], 1'b1);
    $display("test status done");
  endtask
  task automatic t_fault();
    wr(10'h100, 32'h0000_0080);
    flt <= 22'h000010;
    idle(6);
    chk("io fault status", ost[0], 1'b1);
    flt <= 22'h000000;
    idle(6);
    chk("io fault gone", ost[0], 1'b0);
    sck <= 1'b0;
    idle(6);
    chk("so1 self check off", so1, 2'h0);
    sck <= 1'b1;
    idle(8);
    chk("so1 waits manual reset", so1, 2'h0);
    $display("test fault done");
  endtask
  task automatic t_lamp();
    logic [31:0] q;
    wr(10'h024, 32'h1);
    mute <= 1'b1;
    idle(6);
    chk("lamp a lit", la, 1'b1);
    chk("lamp b lit", lb, 1'b1);
    rd(10'h028, q);
    chk("mute cycle", q[9], 1'b1);
    mute <= 1'b0;
    idle(6);
    chk("lamp a dark", la, 1'b0);
    broken <= 1'b1;
    idle(6);
    mute <= 1'b1;
    idle(6);
    chk("mute refused", lb, 1'b0);
    rd(10'h028, q);
    chk("open seen", q[11], 1'b1);
    chk("io fault lamp", q[6], 1'b1);
    mute <= 1'b0;
    broken <= 1'b0;
    idle(4);
    wr(10'h024, 32'h5);
    mute <= 1'b1;
    idle(6);
    chk("mute after clear", la, 1'b1);
    mute <= 1'b0;
    idle(4);
    $display("test lamp done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    t_reset();
    t_and_logic();
    t_on_delay();
    t_off_delay();
    t_manual();
    t_status();
    t_fault();
    t_lamp();
    end_of_test();
  end
endmodule
